// *** design/capture_control_ch23.sv ***
// top: capture control register for channels 2 and 3 with Avalon-MM slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module capture_control_ch23
  import capture_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // capture pins, counter, polarity
  input wire logic cap_in_ch2,
  input wire logic cap_in_ch3,
  input wire logic [CNT_W-1:0] down_counter,
  input wire logic flag_clear_polarity,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [CNT_W-1:0] rise_value_ch2;
    logic [CNT_W-1:0] fall_value_ch2;
    logic [CNT_W-1:0] rise_value_ch3;
    logic [CNT_W-1:0] fall_value_ch3;
    logic [31:0] readdata;
    logic ack;
    logic irq;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  avmm_req_t req;
  edge_pulse_t edges [NUM_CH];
  logic [7:0] ch_next [NUM_CH];
  logic [NUM_CH-1:0] rise_load;
  logic [NUM_CH-1:0] fall_load;
  logic [NUM_CH-1:0] irq_event;
  logic [NUM_CH-1:0] pins;
  logic access;
  logic do_write;
  logic ctrl_sel;

  assign req.address = avs_address;
  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.writedata = avs_writedata;
  assign req.byteenable = avs_byteenable;
  assign pins = {cap_in_ch3, cap_in_ch2};

  // one wait state; a write lands only at the edge where waitrequest is seen low
  assign access = (req.read | req.write) & ~s_q.ack;
  assign do_write = req.write & s_q.ack;
  assign ctrl_sel = do_write & (req.address == CTRL_OFFSET);

  // ****************************************************************
  // per-channel logic
  // ****************************************************************
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam int LSB = (i == 0) ? CH2_LSB : CH3_LSB;
    capture_edge_detect u_edge (
      .clk(clk),
      .srst(srst),
      .pin_in(pins[i]),
      .invert(s_q.ctrl[LSB+F_INVERT]),
      .edges(edges[i])
    );
    capture_channel u_chan (
      .ctrl_byte(s_q.ctrl[LSB+7:LSB]),
      .edges(edges[i]),
      .counter(down_counter),
      .wr_byte(ctrl_sel & req.byteenable[LSB/8]),
      .wr_data(req.writedata[LSB+7:LSB]),
      .clear_polarity(flag_clear_polarity),
      .ctrl_next(ch_next[i]),
      .rise_load(rise_load[i]),
      .fall_load(fall_load[i]),
      .irq_event(irq_event[i])
    );
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ctrl = {8'h00, ch_next[1], 8'h00, ch_next[0]};
    if (rise_load[0]) begin
      s_d.rise_value_ch2 = down_counter;
    end
    if (fall_load[0]) begin
      s_d.fall_value_ch2 = down_counter;
    end
    if (rise_load[1]) begin
      s_d.rise_value_ch3 = down_counter;
    end
    if (fall_load[1]) begin
      s_d.fall_value_ch3 = down_counter;
    end
    // status bits: {ch3 fall, ch3 rise, ch2 fall, ch2 rise}; set wins over clear
    if (do_write & req.address == IRQ_STATUS_OFFSET & req.byteenable[0]) begin
      s_d.irq_status = s_q.irq_status & ~req.writedata[3:0];
    end
    s_d.irq_status = s_d.irq_status | {fall_load[1], rise_load[1], fall_load[0], rise_load[0]};
    if (do_write & req.address == IRQ_MASK_OFFSET & req.byteenable[0]) begin
      s_d.irq_mask = req.writedata[3:0];
    end
    // irq flag of either channel also drives the line
    s_d.irq = (|(s_d.irq_status & s_d.irq_mask)) | s_d.ctrl[CH2_LSB+F_IRQ_FLAG]
              | s_d.ctrl[CH3_LSB+F_IRQ_FLAG];
    s_d.ack = access;
    s_d.readdata = UNMAPPED_READ;
    if (req.read & ~s_q.ack) begin
      unique case (req.address)
        CTRL_OFFSET: s_d.readdata = s_q.ctrl;
        IRQ_STATUS_OFFSET: s_d.readdata = {28'h0000000, s_q.irq_status};
        IRQ_MASK_OFFSET: s_d.readdata = {28'h0000000, s_q.irq_mask};
        RISE_VALUE_CH2_OFFSET: s_d.readdata = {16'h0000, s_q.rise_value_ch2};
        FALL_VALUE_CH2_OFFSET: s_d.readdata = {16'h0000, s_q.fall_value_ch2};
        RISE_VALUE_CH3_OFFSET: s_d.readdata = {16'h0000, s_q.rise_value_ch3};
        FALL_VALUE_CH3_OFFSET: s_d.readdata = {16'h0000, s_q.fall_value_ch3};
        default: s_d.readdata = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.readdata;
  assign avs_waitrequest = ~s_q.ack;
  assign irq = s_q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_fall_sets_ch3: assert property (fall_load[1] |=> s_q.ctrl[23])
    else $error("ch3 fall latch flag not set");
  a_rise_loads_ch3: assert property (
      rise_load[1] |=> s_q.rise_value_ch3 == $past(down_counter))
    else $error("ch3 rise value not captured");
  a_clear_polarity: assert property (
      ctrl_sel & req.byteenable[2] & ~edges[1].rise
      & s_q.ctrl[22] & (req.writedata[22] == flag_clear_polarity) |=> ~s_q.ctrl[22])
    else $error("latched flag not cleared");
  a_rise_irq_ch3: assert property (rise_load[1] & s_q.ctrl[17] |=> s_q.ctrl[20] && irq)
    else $error("ch3 rise irq missing");
  a_fall_irq_ch3: assert property (fall_load[1] & s_q.ctrl[18] |=> s_q.ctrl[20])
    else $error("ch3 fall irq missing");
  a_flag_w0_keeps: assert property (
      ctrl_sel & req.byteenable[2] & ~req.writedata[20]
      & s_q.ctrl[20] |=> s_q.ctrl[20])
    else $error("irq flag lost on write zero");
  a_disabled_holds: assert property (
      ~s_q.ctrl[19] |=> $stable(s_q.rise_value_ch3)
      && $stable(s_q.fall_value_ch3))
    else $error("disabled channel updated");
  a_reserved_zero: assert property (
      s_q.ctrl[31:24] == 8'h00 && s_q.ctrl[15:8] == 8'h00
      && !s_q.ctrl[21] && !s_q.ctrl[5])
    else $error("reserved bits set");
  a_ch2_fall_flag: assert property (fall_load[0] |=> s_q.ctrl[7])
    else $error("ch2 fall latch flag not set");
  a_invert_edge: assert property (
      s_q.ctrl[16] & $stable(s_q.ctrl[16]) & $fell(cap_in_ch3)
      & s_q.ctrl[19] |-> rise_load[1])
    else $error("inverted fall not seen as rise");
  a_bus_answer: assert property ((avs_read | avs_write) & avs_waitrequest |=> ~avs_waitrequest)
    else $error("bus answer late");

  c_ch3_rise: cover property (rise_load[1] ##1 irq);
  c_ch2_fall: cover property (fall_load[0]);
  c_set_clear: cover property (ctrl_sel & edges[1].fall & s_q.ctrl[19]);
  c_read_ctrl: cover property (avs_read & ~avs_waitrequest & avs_address == CTRL_OFFSET);

endmodule
`default_nettype wire

// *** common/capture_pkg.sv ***
// package: register map, field positions and carrier types of the capture control block
package capture_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h54;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h58;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h5C;
  localparam logic [7:0] RISE_VALUE_CH2_OFFSET = 8'h60;
  localparam logic [7:0] FALL_VALUE_CH2_OFFSET = 8'h64;
  localparam logic [7:0] RISE_VALUE_CH3_OFFSET = 8'h68;
  localparam logic [7:0] FALL_VALUE_CH3_OFFSET = 8'h6C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ****************************************************************
  // field positions within a channel byte
  // ****************************************************************
  localparam int CH2_LSB = 0;
  localparam int CH3_LSB = 16;
  localparam int F_INVERT = 0;
  localparam int F_RISE_IE = 1;
  localparam int F_FALL_IE = 2;
  localparam int F_ENABLE = 3;
  localparam int F_IRQ_FLAG = 4;
  localparam int F_RISE_LATCHED = 6;
  localparam int F_FALL_LATCHED = 7;
  localparam logic [7:0] CH_BYTE_MASK = 8'hDF;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 2;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic readdatavalid;
    logic waitrequest;
  } avmm_rsp_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_pulse_t;

endpackage

// *** design/capture_edge_detect.sv ***
// one channel: optional inversion of the pin and rise/fall pulse detection
`timescale 1ns/1ps
`default_nettype none
module capture_edge_detect
  import capture_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pin and control
  input wire logic pin_in,
  input wire logic invert,
  // edge pulses
  output edge_pulse_t edges
);

  typedef struct packed {
    logic prev;
    logic primed;
  } det_state_t;

  det_state_t s_q;
  det_state_t s_d;
  logic level;

  assign level = pin_in ^ invert;

  always_comb begin
    s_d = s_q;
    s_d.prev = level;
    s_d.primed = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // no edge is reported in the first cycle after reset
  assign edges = '{rise: s_q.primed & level & ~s_q.prev, fall: s_q.primed & ~level & s_q.prev};

endmodule
`default_nettype wire

// *** design/capture_channel.sv ***
// one channel: latch values and flag next-state logic
`timescale 1ns/1ps
`default_nettype none
module capture_channel
  import capture_pkg::*;
(
  // control byte and events
  input wire logic [7:0] ctrl_byte,
  input wire edge_pulse_t edges,
  input wire logic [CNT_W-1:0] counter,
  // software write to this byte
  input wire logic wr_byte,
  input wire logic [7:0] wr_data,
  input wire logic clear_polarity,
  // results
  output logic [7:0] ctrl_next,
  output logic rise_load,
  output logic fall_load,
  output logic irq_event
);

  logic en;
  logic rise_hit;
  logic fall_hit;
  logic [7:0] b;

  assign en = ctrl_byte[F_ENABLE];
  assign rise_hit = en & edges.rise;
  assign fall_hit = en & edges.fall;
  assign rise_load = rise_hit;
  assign fall_load = fall_hit;
  assign irq_event = (rise_hit & ctrl_byte[F_RISE_IE]) | (fall_hit & ctrl_byte[F_FALL_IE]);

  always_comb begin
    b = ctrl_byte;
    if (wr_byte) begin
      b[3:0] = wr_data[3:0];
      if (wr_data[F_IRQ_FLAG]) begin
        b[F_IRQ_FLAG] = 1'b0;
      end
      if (wr_data[F_RISE_LATCHED] == clear_polarity) begin
        b[F_RISE_LATCHED] = 1'b0;
      end
      if (wr_data[F_FALL_LATCHED] == clear_polarity) begin
        b[F_FALL_LATCHED] = 1'b0;
      end
    end
    // hardware set wins over a same-cycle clear
    if (rise_hit) begin
      b[F_RISE_LATCHED] = 1'b1;
    end
    if (fall_hit) begin
      b[F_FALL_LATCHED] = 1'b1;
    end
    if (irq_event) begin
      b[F_IRQ_FLAG] = 1'b1;
    end
    ctrl_next = b & CH_BYTE_MASK;
  end

endmodule
`default_nettype wire

// *** sim/capture_pin_model.sv ***
// gpio side model: drives the two capture pins
`timescale 1ns/1ps
`default_nettype none
module capture_pin_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // toggle request, bit 0 is channel 2
  input wire logic [1:0] flip,
  // capture pins
  output logic [1:0] pins
);
  // pins move only after an edge, as a synchronised gpio would
  always_ff @(posedge clk) begin
    if (srst) begin
      pins <= 2'h0;
    end else begin
      pins <= pins ^ flip;
    end
  end
endmodule
`default_nettype wire

// *** sim/capture_control_ch23_tb.sv ***
// testbench: capture control for channels 2 and 3 against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module capture_control_ch23_tb;
  import capture_pkg::*;
  logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'h0;
  logic [CNT_W-1:0] down_counter = '0;
  logic flag_clear_polarity = 1'b0;
  logic [1:0] flip = 2'h0, pins;
  int seed = 19, bad_count = 0, check_count = 0;
  int ctrl = 0, st = 0, mk = 0, cnt = 0, pm = 0, pol = 0, d, be, f;
  int val[4] = '{0, 0, 0, 0};
  int eff[2] = '{0, 0};

  always #2.5 clk = ~clk;

  capture_control_ch23 capture_control_ch23_i (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cap_in_ch2(pins[0]), .cap_in_ch3(pins[1]), .down_counter(down_counter),
    .flag_clear_polarity(flag_clear_polarity), .irq(irq));
  capture_pin_model capture_pin_model_i (.clk(clk), .srst(srst), .flip(flip), .pins(pins));

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_irq(input logic exp);
    check_count++;
    if (irq !== exp) begin
      bad_count++;
      $display("Error irq expected %b seen %b", exp, irq);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge, released right after
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      input logic [3:0] lanes);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    avs_byteenable <= lanes;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      end_of_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // ****************************************************************
  // behavioural model
  // ****************************************************************
  function automatic int wbyte(int o, int wd, int p);
    int clr;
    clr = (wd & 'h10) | (((wd >> 6 & 1) == p) ? 'h40 : 0) | (((wd >> 7 & 1) == p) ? 'h80 : 0);
    return (wd & 'h0F) | (o & 'hD0 & ~clr);
  endfunction

  task automatic ev(int c, int r);
    int b;
    b = ctrl >> (16 * c) & 'hFF;
    if (b & 8) begin
      b |= r ? 'h40 : 'h80;
      if ((r && (b & 2)) || (!r && (b & 4))) begin
        b |= 'h10;
      end
      val[c * 2 + !r] = cnt;
      st |= 1 << (c * 2 + !r);
      ctrl = ctrl & ~('hFF << 16 * c) | b << 16 * c;
    end
  endtask

  // an inverter change is an edge of its own
  task automatic sync(int c);
    int e;
    e = (pm >> c & 1) ^ (ctrl >> (16 * c) & 1);
    if (e != eff[c]) begin
      eff[c] = e;
      ev(c, e);
    end
  endtask

  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, CTRL_OFFSET, 32'h0, 4'hF);
    check_reg("ctrl reset", CTRL_RESET, rd);
    check_irq(1'b0);
    bus(1'b1, 8'h00, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 8'h00, 32'h0, 4'hF);
    check_reg("unmapped", UNMAPPED_READ, rd);
    for (int i = 0; i < 300; i++) begin
      cnt = $random(seed) & 'hFFFF;
      pol = $random(seed) & 1;
      down_counter <= CNT_W'(cnt);
      flag_clear_polarity <= pol[0];
      d = $random(seed);
      bus(1'b1, IRQ_MASK_OFFSET, d, 4'hF);
      mk = d & 'hF;
      d = $random(seed);
      bus(1'b1, IRQ_STATUS_OFFSET, d, 4'hF);
      st &= ~d;
      d = $random(seed);
      be = $random(seed);
      bus(1'b1, CTRL_OFFSET, d, 4'(be));
      for (int k = 0; k < 2; k++) begin
        if (be >> (2 * k) & 1) begin
          ctrl = ctrl & ~('hFF << 16 * k) | wbyte(ctrl >> 16 * k & 'hFF, d >> 16 * k & 'hFF, pol) << 16 * k;
        end
      end
      sync(0);
      sync(1);
      repeat (4) @(posedge clk);
      f = $random(seed) & 3;
      flip <= 2'(f);
      @(posedge clk);
      flip <= 2'h0;
      pm ^= f;
      sync(0);
      sync(1);
      repeat (4) @(posedge clk);
      check_irq((st & mk) != 0 || (ctrl & 'h0010_0010) != 0);
      bus(1'b0, CTRL_OFFSET, 32'h0, 4'hF);
      check_reg("ctrl", ctrl, rd);
      bus(1'b0, IRQ_STATUS_OFFSET, 32'h0, 4'hF);
      check_reg("status", st, rd);
      for (int k = 0; k < 4; k++) begin
        bus(1'b0, RISE_VALUE_CH2_OFFSET + 8'(4 * k), 32'h0, 4'hF);
        check_reg("value", val[k], rd);
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
